//--- ext_bus_pkg.sv
// constants and types shared by the multiplexed external memory bus block
// assumes a core that paces it with fetch and data requests on one clock
package ext_bus_pkg;

	// machine cycle layout: twelve slots, two fetch halves of six slots
	localparam int SLOT_DIV_DEF = 2;
	localparam logic [3:0] MC_LAST_SLOT = 4'hb;
	localparam logic [3:0] HALF_SLOTS = 4'h6;
	localparam logic [3:0] HALF_LAST = 4'h5;

	// positions within a bus cycle, counted in slots from its start
	localparam logic [3:0] ALE_END = 4'h1;
	localparam logic [3:0] ADDR_END = 4'h2;
	localparam logic [3:0] PRD_START = 4'h3;
	localparam logic [3:0] WDATA_START = 4'h3;
	localparam logic [3:0] STROBE_START = 4'h4;
	localparam logic [3:0] STROBE_END = 4'ha;

	// values after reset, and the default on-chip code top
	localparam logic [7:0] LOW_PORT_RST = 8'hff;
	localparam logic [7:0] UPPER_PORT_RST = 8'hff;
	localparam logic [7:0] BUS_FLOAT_FILL = 8'hff;
	localparam logic [15:0] ROM_TOP_DEF = 16'h1fff;

	// clocks after reset release before the strap is taken
	localparam logic [2:0] STRAP_SETTLE = 3'h5;

	typedef enum logic [2:0]
	{
		BUS_IDLE = 3'b001,
		BUS_CODE = 3'b010,
		BUS_DATA = 3'b100
	} bus_state_t;

endpackage : ext_bus_pkg

//--- ext_mem_bus.sv
// multiplexed external memory bus: code fetch, data read, data write
// assumes an external address latch on addr_latch_out and a core that holds
// data_req_in until data_done_out; pin inputs are asynchronous to ref_clk_in
// Functional notes
// - low address then data share mux lines
// - upper address lines carry high address byte
// - latch strobe pulses at each cycle start
// - strap low sends all code fetches outside
// - strap high: on-chip up to and including top, else outside
// - strap taken after reset, then held
// - program read strobe only for code fetches
// - data read and write strobes for data
// - only code fetch, data read, data write
// - two fetches per cycle, unneeded one discarded
// - data cycle removes two program read pulses
// - data cycle twice a fetch cycle long
// - internal code: no program read strobe, no address
// - latch strobe twice per cycle as clock
// - data move cycle skips one latch pulse
// - no bus cycles when idle or powered down
// - idle bus: low floats, upper shows register
// - bus cycle fills low register with ones
// - short address puts upper register on pins
`timescale 1ns/1ps
`default_nettype none

module ext_mem_bus
	import ext_bus_pkg::*;
#(
	parameter int SLOT_DIV = SLOT_DIV_DEF,
	parameter logic [15:0] ROM_TOP = ROM_TOP_DEF
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic idle_mode_in,
	input wire logic powerdown_in,
	input wire logic [15:0] fetch_addr_in,
	input wire logic fetch_needed_in,
	input wire logic data_req_in,
	input wire logic data_we_in,
	input wire logic data_wide_in,
	input wire logic [15:0] data_addr_in,
	input wire logic [7:0] data_wdata_in,
	input wire logic port_low_wr_in,
	input wire logic port_upper_wr_in,
	input wire logic [7:0] port_wdata_in,
	input wire logic code_select_strap_n_in,
	input wire logic [7:0] mux_addr_data_in,
	output logic [7:0] mux_addr_data_out,
	output logic mux_addr_data_oe_n_out,
	output logic [7:0] upper_addr_out,
	output logic addr_latch_out,
	output logic prog_read_n_out,
	output logic data_read_n_out,
	output logic data_write_n_out,
	output logic [7:0] code_byte_out,
	output logic fetch_done_out,
	output logic fetch_ext_out,
	output logic pc_advance_out,
	output logic [7:0] data_rdata_out,
	output logic data_done_out,
	output logic [7:0] low_port_reg_out,
	output logic [7:0] upper_port_reg_out,
	output logic strap_latched_n_out
);

	// pin synchronisers: stage one feeds stage two only
	logic strap_s1_r, strap_s2_r, strap_s3_r, strap_filt_r, strap_filt_nxt;
	logic [7:0] bus_s1_r, bus_s2_r, bus_s3_r, bus_filt_r, bus_filt_nxt;
	logic strap_r, strap_nxt, cap_done_r, cap_done_nxt;
	logic [2:0] cap_cnt_r, cap_cnt_nxt;

	// a change counts once stages two and three agree
	always_comb
	begin
		strap_filt_nxt = (strap_s2_r == strap_s3_r) ? strap_s3_r : strap_filt_r;
		bus_filt_nxt = bus_filt_r;
		for (int i = 0; i < 8; i++)
		begin
			if (bus_s2_r[i] == bus_s3_r[i])
				bus_filt_nxt[i] = bus_s3_r[i];
		end
		cap_cnt_nxt = cap_cnt_r;
		cap_done_nxt = cap_done_r;
		strap_nxt = strap_r;
		// strap caught once the filter has settled, then frozen until reset
		if (!cap_done_r)
		begin
			if (cap_cnt_r == STRAP_SETTLE)
			begin
				strap_nxt = strap_filt_r;
				cap_done_nxt = 1'b1;
			end
			else
				cap_cnt_nxt = cap_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_s1_r <= 1'b1;
			strap_s2_r <= 1'b1;
			strap_s3_r <= 1'b1;
			strap_filt_r <= 1'b1;
			bus_s1_r <= BUS_FLOAT_FILL;
			bus_s2_r <= BUS_FLOAT_FILL;
			bus_s3_r <= BUS_FLOAT_FILL;
			bus_filt_r <= BUS_FLOAT_FILL;
			strap_r <= 1'b1;
			cap_done_r <= 1'b0;
			cap_cnt_r <= 3'h0;
		end
		else
		begin
			strap_s1_r <= code_select_strap_n_in;
			strap_s2_r <= strap_s1_r;
			strap_s3_r <= strap_s2_r;
			strap_filt_r <= strap_filt_nxt;
			bus_s1_r <= mux_addr_data_in;
			bus_s2_r <= bus_s1_r;
			bus_s3_r <= bus_s2_r;
			bus_filt_r <= bus_filt_nxt;
			strap_r <= strap_nxt;
			cap_done_r <= cap_done_nxt;
			cap_cnt_r <= cap_cnt_nxt;
		end
	end

	// slot divider: every slot is one enable pulse
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic slot_en;

	always_comb
	begin
		slot_en = (div_cnt_r == 8'(SLOT_DIV - 1));
		div_cnt_nxt = slot_en ? 8'h0 : div_cnt_r + 8'h1;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
			div_cnt_r <= 8'h0;
		else
			div_cnt_r <= div_cnt_nxt;
	end

	// sequencer state, latched requests, port registers and pins
	bus_state_t state_r, state_nxt;
	logic [3:0] slot_r, slot_nxt, half_pos;
	logic [15:0] fa_r, fa_nxt, da_r, da_nxt;
	logic fetch_ext_r, fetch_ext_nxt, need_r, need_nxt;
	logic we_r, we_nxt, wide_r, wide_nxt;
	logic [7:0] wd_r, wd_nxt, low_r, low_nxt, upper_r, upper_nxt;
	logic active, start_mc, new_half, ext_cycle;
	logic [7:0] mad_nxt, ua_nxt, cb_nxt, rd_nxt;
	logic oe_n_nxt, ale_nxt, prd_n_nxt, drd_n_nxt, dwr_n_nxt;
	logic fdone_nxt, fext_nxt, pcadv_nxt, ddone_nxt;
	logic [8:0] data_len_r, data_len_nxt;

	always_comb
	begin
		// idle and powerdown park the bus at a machine cycle boundary
		active = cap_done_r && !idle_mode_in && !powerdown_in;
		start_mc = slot_en && active && (state_r == BUS_IDLE || slot_r == MC_LAST_SLOT);
		new_half = start_mc || (slot_en && state_r == BUS_CODE && slot_r == HALF_LAST);
		half_pos = (state_r == BUS_CODE && slot_r >= HALF_SLOTS) ? slot_r - HALF_SLOTS : slot_r;
		ext_cycle = (state_r == BUS_DATA) || (state_r == BUS_CODE && fetch_ext_r);
		state_nxt = state_r;
		slot_nxt = slot_r;
		da_nxt = da_r;
		we_nxt = we_r;
		wide_nxt = wide_r;
		wd_nxt = wd_r;
		fa_nxt = fa_r;
		fetch_ext_nxt = fetch_ext_r;
		need_nxt = need_r;
		if (start_mc)
		begin
			slot_nxt = 4'h0;
			// a pending data move takes the whole cycle, dropping both fetches
			state_nxt = data_req_in ? BUS_DATA : BUS_CODE;
			da_nxt = data_addr_in;
			we_nxt = data_we_in;
			wide_nxt = data_wide_in;
			wd_nxt = data_wdata_in;
		end
		else if (slot_en && state_r != BUS_IDLE)
		begin
			if (slot_r == MC_LAST_SLOT)
			begin
				state_nxt = BUS_IDLE;
				slot_nxt = 4'h0;
			end
			else
				slot_nxt = slot_r + 4'h1;
		end
		// each fetch half takes a fresh address and the strap decision
		if (new_half && !(start_mc && data_req_in))
		begin
			fa_nxt = fetch_addr_in;
			fetch_ext_nxt = !strap_r || (fetch_addr_in > ROM_TOP);
			need_nxt = fetch_needed_in;
		end
		// latch strobe every half in code cycles, once in data cycles
		ale_nxt = (state_r != BUS_IDLE) && (half_pos <= ALE_END);
		oe_n_nxt = 1'b1;
		mad_nxt = BUS_FLOAT_FILL;
		if (ext_cycle && half_pos <= ADDR_END)
		begin
			oe_n_nxt = 1'b0;
			mad_nxt = (state_r == BUS_DATA) ? da_r[7:0] : fa_r[7:0];
		end
		else if (state_r == BUS_DATA && we_r && half_pos >= WDATA_START)
		begin
			oe_n_nxt = 1'b0;
			mad_nxt = wd_r;
		end
		// upper lines show the register unless a 16-bit address is out
		ua_nxt = upper_r;
		if (state_r == BUS_CODE && fetch_ext_r)
			ua_nxt = fa_r[15:8];
		else if (state_r == BUS_DATA && wide_r)
			ua_nxt = da_r[15:8];
		// internal code keeps the program read strobe high
		prd_n_nxt = !(state_r == BUS_CODE && fetch_ext_r && half_pos >= PRD_START);
		drd_n_nxt = !(state_r == BUS_DATA && !we_r && half_pos >= STROBE_START && half_pos <= STROBE_END);
		dwr_n_nxt = !(state_r == BUS_DATA && we_r && half_pos >= STROBE_START && half_pos <= STROBE_END);
		// results sampled at the last strobe slot while the strobe is still low
		fdone_nxt = 1'b0;
		pcadv_nxt = 1'b0;
		fext_nxt = fetch_ext_out;
		cb_nxt = code_byte_out;
		if (slot_en && state_r == BUS_CODE && half_pos == HALF_LAST)
		begin
			fdone_nxt = 1'b1;
			fext_nxt = fetch_ext_r;
			pcadv_nxt = need_r;
			if (fetch_ext_r)
				cb_nxt = bus_filt_r;
		end
		ddone_nxt = 1'b0;
		rd_nxt = data_rdata_out;
		if (slot_en && state_r == BUS_DATA && slot_r == STROBE_END)
		begin
			ddone_nxt = 1'b1;
			if (!we_r)
				rd_nxt = bus_filt_r;
		end
		// a bus cycle owns the low port and wipes its register
		low_nxt = low_r;
		if (ext_cycle)
			low_nxt = LOW_PORT_RST;
		else if (port_low_wr_in)
			low_nxt = port_wdata_in;
		upper_nxt = port_upper_wr_in ? port_wdata_in : upper_r;
		// clocks spent in a data cycle, cleared at its last slot so back to back cycles count alike
		data_len_nxt = (state_r == BUS_DATA && !(slot_en && slot_r == MC_LAST_SLOT)) ? data_len_r + 9'h1 : 9'h0;
	end

	// pins come from flops, so they trail the sequencer by one clock
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_r <= BUS_IDLE;
			slot_r <= 4'h0;
			fa_r <= 16'h0;
			da_r <= 16'h0;
			fetch_ext_r <= 1'b0;
			need_r <= 1'b0;
			we_r <= 1'b0;
			wide_r <= 1'b0;
			wd_r <= 8'h0;
			low_r <= LOW_PORT_RST;
			upper_r <= UPPER_PORT_RST;
			mux_addr_data_out <= BUS_FLOAT_FILL;
			mux_addr_data_oe_n_out <= 1'b1;
			upper_addr_out <= UPPER_PORT_RST;
			addr_latch_out <= 1'b0;
			prog_read_n_out <= 1'b1;
			data_read_n_out <= 1'b1;
			data_write_n_out <= 1'b1;
			code_byte_out <= 8'h0;
			fetch_done_out <= 1'b0;
			fetch_ext_out <= 1'b0;
			pc_advance_out <= 1'b0;
			data_rdata_out <= 8'h0;
			data_done_out <= 1'b0;
			data_len_r <= 9'h0;
		end
		else
		begin
			state_r <= state_nxt;
			slot_r <= slot_nxt;
			fa_r <= fa_nxt;
			da_r <= da_nxt;
			fetch_ext_r <= fetch_ext_nxt;
			need_r <= need_nxt;
			we_r <= we_nxt;
			wide_r <= wide_nxt;
			wd_r <= wd_nxt;
			low_r <= low_nxt;
			upper_r <= upper_nxt;
			mux_addr_data_out <= mad_nxt;
			mux_addr_data_oe_n_out <= oe_n_nxt;
			upper_addr_out <= ua_nxt;
			addr_latch_out <= ale_nxt;
			prog_read_n_out <= prd_n_nxt;
			data_read_n_out <= drd_n_nxt;
			data_write_n_out <= dwr_n_nxt;
			code_byte_out <= cb_nxt;
			fetch_done_out <= fdone_nxt;
			fetch_ext_out <= fext_nxt;
			pc_advance_out <= pcadv_nxt;
			data_rdata_out <= rd_nxt;
			data_done_out <= ddone_nxt;
			data_len_r <= data_len_nxt;
		end
	end

	assign low_port_reg_out = low_r;
	assign upper_port_reg_out = upper_r;
	assign strap_latched_n_out = strap_r;

	a_data_prd_off: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$past(state_r == BUS_DATA) |-> prog_read_n_out)
		else $error("program read strobe during data cycle");
	a_internal_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$past(state_r == BUS_CODE && !fetch_ext_r) |-> prog_read_n_out && mux_addr_data_oe_n_out)
		else $error("internal fetch touched the bus");
	a_idle_release: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$past(state_r == BUS_IDLE) |-> mux_addr_data_oe_n_out && !addr_latch_out
		&& upper_addr_out == $past(upper_r))
		else $error("idle bus not released");
	a_strap_held: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		cap_done_r && $past(cap_done_r) |-> $stable(strap_r))
		else $error("strap changed after capture");
	a_data_length: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(state_r == BUS_DATA && slot_en && slot_r == MC_LAST_SLOT) |-> data_len_r == 9'(12 * SLOT_DIV - 1))
		else $error("data cycle length wrong");
	a_ale_rise_slot: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(addr_latch_out) |-> $past(slot_r) == 4'h0
		|| ($past(slot_r) == HALF_SLOTS && $past(state_r) == BUS_CODE))
		else $error("latch strobe at wrong slot");
	a_low_port_ones: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$past(state_r == BUS_DATA) |-> low_r == LOW_PORT_RST)
		else $error("low port register not filled");
	a_page_select: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$past(state_r == BUS_DATA && !wide_r) |-> upper_addr_out == $past(upper_r))
		else $error("page register not on upper lines");
	a_strap_low_ext: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		fetch_done_out && !strap_r |-> fetch_ext_out)
		else $error("fetch kept on chip with strap low");
	a_one_strobe: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!(!data_read_n_out && !data_write_n_out) && !(!prog_read_n_out && !data_read_n_out))
		else $error("two read or write strobes at once");

endmodule : ext_mem_bus

`default_nettype wire

//--- ext_mem_partner.sv
// far side model: address latch, code store and a small data store
// assumes strobes from the bus block and the resolved wire on mux_in
`timescale 1ns/1ps
`default_nettype none

module ext_mem_partner
(
	input wire logic ale_in,
	input wire logic [7:0] mux_in,
	input wire logic [7:0] hi_in,
	input wire logic prd_n_in,
	input wire logic drd_n_in,
	input wire logic dwr_n_in,
	output logic [7:0] drv_out,
	output logic [7:0] hi_out
);
	logic [7:0] lo_r;
	logic [7:0] last_r = 8'h00;
	logic [7:0] ram [0:255];

	// outside latch holds the low byte once the strobe falls
	always @(negedge ale_in)
	begin
		lo_r = mux_in;
		hi_out = hi_in;
	end

	always @(posedge dwr_n_in)
		ram[lo_r] = mux_in;

	// drive only under a read strobe; released lines show the inverse of the last byte
	always @*
		if (!prd_n_in)
			drv_out = lo_r ^ hi_out ^ 8'h5a;
		else if (!drd_n_in)
			drv_out = ram[lo_r];
		else
			drv_out = ~last_r;

	always @(negedge prd_n_in or negedge drd_n_in)
		#1 last_r = drv_out;
endmodule : ext_mem_partner
`default_nettype wire

//--- external_memory_bus_interface_bench.sv
// bench for the external memory bus block with the far side model
// assumes default slot divider and on-chip code top
`timescale 1ns/1ps
`default_nettype none

module external_memory_bus_interface_bench;
	logic clk, rst, idl, pd, need, req, we, wide, plw, puw, strap;
	logic [15:0] fa, da;
	logic [7:0] wd, pw, mux, mo, up, cb, rdd, lp, upp, hi, drv;
	logic oe_n, ale, prd, drd, dwr, fd, fx, pca, dd, sl;
	logic ale_q, prd_q, drd_q, dwr_q;
	int err_count, checks, cyc, last_ale, gap, n_ale, n_prd, n_rd, n_wr, n_oe, n_pc;

	// resolved wire: device drive wins while its enable is low
	assign mux = oe_n ? drv : mo;

	ext_mem_bus #(.SLOT_DIV(2), .ROM_TOP(16'h1fff)) u_dut (.ref_clk_in(clk), .rst_in(rst), .idle_mode_in(idl),
		.powerdown_in(pd), .fetch_addr_in(fa), .fetch_needed_in(need), .data_req_in(req), .data_we_in(we),
		.data_wide_in(wide), .data_addr_in(da), .data_wdata_in(wd), .port_low_wr_in(plw),
		.port_upper_wr_in(puw), .port_wdata_in(pw), .code_select_strap_n_in(strap), .mux_addr_data_in(mux),
		.mux_addr_data_out(mo), .mux_addr_data_oe_n_out(oe_n), .upper_addr_out(up), .addr_latch_out(ale),
		.prog_read_n_out(prd), .data_read_n_out(drd), .data_write_n_out(dwr), .code_byte_out(cb),
		.fetch_done_out(fd), .fetch_ext_out(fx), .pc_advance_out(pca), .data_rdata_out(rdd),
		.data_done_out(dd), .low_port_reg_out(lp), .upper_port_reg_out(upp), .strap_latched_n_out(sl));

	ext_mem_partner u_mem (.ale_in(ale), .mux_in(mux), .hi_in(up), .prd_n_in(prd), .drd_n_in(drd),
		.dwr_n_in(dwr), .drv_out(drv), .hi_out(hi));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// edge and level counters, sampled just after the rising edge so the drivers read them race free
	always @(posedge clk)
	begin
		#1;
		cyc++;
		if (ale && !ale_q)
		begin
			n_ale++;
			gap = cyc - last_ale;
			last_ale = cyc;
		end
		n_prd += (!prd && prd_q);
		n_rd += (!drd && drd_q);
		n_wr += (!dwr && dwr_q);
		n_oe += (oe_n === 1'b0);
		n_pc += (pca === 1'b1);
		{ale_q, prd_q, drd_q, dwr_q} = {ale, prd, drd, dwr};
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// which: 0 fetch done, 1 data done, 2 any latch pulse
	task automatic wait_for(input int which);
		for (int i = 0; i < 200; i++)
		begin
			@(negedge clk);
			if ((which == 0 && fd === 1'b1) || (which == 1 && dd === 1'b1) || (which == 2 && n_ale != 0))
				return;
		end
		err_count++;
		$display("wrong value at %0t: wait ran out", $time);
		report_and_stop();
	endtask : wait_for

	task automatic clr();
		{n_ale, n_prd, n_rd, n_wr, n_oe, n_pc} = '0;
	endtask : clr

	// two fetch halves: one whole machine cycle
	task automatic mcycle();
		wait_for(0);
		wait_for(0);
	endtask : mcycle

	task automatic do_reset(input logic s);
		strap = s;
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		wait_for(0);
	endtask : do_reset

	task automatic sc_ext_fetch();
		fa = 16'h0100;
		mcycle();
		clr();
		mcycle();
		chk(n_ale, 2);
		chk(n_prd, 2);
		chk(n_pc, 2);
		chk(gap, 12);
		chk(cb, 8'h5b);
		chk(hi, 8'h01);
		chk(sl, 1'b0);
		strap = 1'b1;
		need = 1'b0;
		// the half already under way took need high; let it finish first
		wait_for(0);
		clr();
		mcycle();
		chk(n_pc, 0);
		chk(fx, 1'b1);
		chk(sl, 1'b0);
	endtask : sc_ext_fetch

	task automatic sc_int_fetch();
		need = 1'b1;
		mcycle();
		clr();
		mcycle();
		chk(n_ale, 2);
		chk(n_prd, 0);
		chk(n_oe, 0);
		chk(fx, 1'b0);
		chk(sl, 1'b1);
		{pw, plw} = {8'h3c, 1'b1};
		@(negedge clk);
		{pw, plw, puw} = {8'ha5, 2'b01};
		@(negedge clk);
		puw = 1'b0;
		@(negedge clk);
		chk(lp, 8'h3c);
		chk(up, 8'ha5);
	endtask : sc_int_fetch

	task automatic sc_idle();
		for (int k = 0; k < 2; k++)
		begin
			{idl, pd} = k ? 2'b01 : 2'b10;
			repeat (48) @(negedge clk);
			clr();
			repeat (48) @(negedge clk);
			chk(n_ale, 0);
			chk(oe_n, 1'b1);
			chk(up, 8'ha5);
			{idl, pd} = 2'b00;
		end
	endtask : sc_idle

	task automatic sc_far_fetch();
		fa = 16'h2345;
		mcycle();
		mcycle();
		chk(fx, 1'b1);
		chk(cb, 8'h3c);
		chk(lp, 8'hff);
		chk(upp, 8'ha5);
	endtask : sc_far_fetch

	task automatic sc_data(input logic w, input logic wi, input logic [7:0] hexp);
		{we, wide, req} = {w, wi, 1'b1};
		for (int i = 0; i < 200 && dd !== 1'b1; i++)
		begin
			@(negedge clk);
			if (fd === 1'b1)
				clr();
		end
		req = 1'b0;
		if (dd !== 1'b1)
		begin
			err_count++;
			$display("wrong value at %0t: data done never came", $time);
			report_and_stop();
		end
		chk(n_ale, 1);
		chk(n_prd, 0);
		chk(n_rd, !w);
		chk(n_wr, w);
		chk(hi, hexp);
		chk(lp, 8'hff);
		chk(rdd, w ? 8'h00 : 8'hc3);
		clr();
		wait_for(2);
		chk(gap, 24);
	endtask : sc_data

	initial
	begin
		{err_count, checks, cyc, last_ale, gap} = '0;
		clr();
		{rst, idl, pd, req, we, wide, plw, puw, need} = 9'h101;
		{fa, da, wd, pw, strap} = {16'h0100, 16'h7742, 8'hc3, 8'h00, 1'b0};
		{ale_q, prd_q, drd_q, dwr_q} = 4'h7;
		do_reset(1'b0);
		sc_ext_fetch();
		do_reset(1'b1);
		sc_int_fetch();
		sc_idle();
		sc_far_fetch();
		sc_data(1'b1, 1'b1, 8'h77);
		sc_data(1'b0, 1'b0, 8'ha5);
		report_and_stop();
	end
endmodule : external_memory_bus_interface_bench
`default_nettype wire
